// ==== rtl/adc_link_defines.svh ====
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

// Pin synchroniser positions and idle levels
`define PIN_SCLK          2'h0
`define PIN_SEL           2'h1
`define PIN_SYNC          2'h2
`define PIN_IDLE          3'h6

// Frame layout and counts, in serial clocks
`define FRAME_BITS        5'h10
`define SAMPLE_FIRST      5'h04
`define SHORT_MIN         5'h04
`define SHORT_MAX         5'h07
`define PAD_BITS          4'h0
`define SAR_TOP           12'h800

// Conversion timing
`define CONV_CLOCKS       6'h0E
`define OVERHEAD_NS       16'h0064
`define SYS_CLK_MHZ       16'h0014

// Host frame lengths, in serial clocks
`define SHORT_FRAME_SCLKS 6'h05
`define HOST_MARGIN_SCLKS 6'h03

`endif

// ==== rtl/adc_link_pkg.sv ====
package adc_link_pkg;

    typedef logic [11:0] code_t;
    typedef logic [15:0] frame_t;

    typedef enum logic [1:0] {
        VAR_SINGLE = 2'h0,
        VAR_DUAL   = 2'h1,
        VAR_PSEUDO = 2'h2
    } variant_t;

    typedef enum logic [4:0] {
        ST_IDLE     = 5'h01,
        ST_SHIFT    = 5'h02,
        ST_CONV     = 5'h04,
        ST_OVERHEAD = 5'h08,
        ST_WAIT     = 5'h10
    } dev_state_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'h1,
        H_LEAD = 4'h2,
        H_RUN  = 4'h4,
        H_GAP  = 4'h8
    } host_state_t;

endpackage

// ==== rtl/adc_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface adc_link_if;
    logic sclk;
    logic select_or_sync_n;
    logic frame_sync_in;
    logic sdo_data;
    logic sdo_oe;
    wire  sdo_line;

    // Released line shows the inverse of the last bit, so stale data is never mistaken
    assign sdo_line = sdo_oe ? sdo_data : ~sdo_data;

    modport device_end (
        input  sclk,
        input  select_or_sync_n,
        input  frame_sync_in,
        output sdo_data,
        output sdo_oe
    );

    modport host_end (
        output sclk,
        output select_or_sync_n,
        output frame_sync_in,
        input  sdo_line
    );
endinterface

`default_nettype wire

// ==== rtl/adc_frame_device.sv ====
// Functional notes
// R1 - Output released while select high, driven after fall
// R2 - Output released after sixteenth serial clock
// R3 - MSB first, valid at falling clock
// R4 - Sixteen-bit frame: twelve result, four pad
// R5 - Codes span 000h to FFFh
// R6 - Select fall starts cycle, bits change rising
// R7 - Frame sync fall starts cycle, select grounded
// R8 - Host uses clock polarity 0, phase 1
// R9 - Combined pin fall starts cycle on dual
// R10 - Short 4-7 clock frame resets channel zero
// R11 - Completed frame toggles channel on rise
// R12 - Sample twelve clocks from fifth clock
// R13 - Conversion begins after sixteenth clock edge
// R14 - Conversion 14 half-rate clocks plus overhead
// R15 - Select rise aborts unfinished conversion
// R16 - Result shifted out during following frame
// R17 - Fourteen conversion clocks at half rate
// R18 - Power down after conversion, wake on fall
// R19 - Frame sync or select, first fall wins
// R20 - Pad bits driven as zero
`include "adc_link_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module adc_frame_device
    import adc_link_pkg::*;
#(
    parameter variant_t VARIANT = VAR_DUAL
)(
    input  wire logic      clk_sys_i,
    input  wire logic      rst_i,
    adc_link_if.device_end link,
    input  wire code_t     analog_channel_zero_i,
    input  wire code_t     analog_channel_one_i,
    output var  code_t     result_bits_o,
    output var  logic      channel_o,
    output var  logic      powered_down_o,
    output var  logic      sampling_o,
    output var  logic      conv_done_o,
    output var  logic      conv_abort_o
);

    localparam logic [5:0] CONV_EDGES = `CONV_CLOCKS << 1;
    localparam int         OVH_CYC_I  = (`OVERHEAD_NS * `SYS_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] OVH_LAST   = 3'((OVH_CYC_I < 1) ? 0 : OVH_CYC_I - 1);

    logic [2:0] pin_raw;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [2:0] pin_lvl;
    logic [2:0] pin_prev;
    logic [2:0] next_pin_lvl;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sel_fall;
    logic       sel_rise;
    logic       sync_fall;
    logic       frame_start;
    code_t      chan_in;

    dev_state_t state;
    dev_state_t next_state;
    logic [4:0] fall_cnt;
    logic [4:0] next_fall;
    frame_t     shift;
    frame_t     next_shift;
    logic       sdo;
    logic       next_sdo;
    logic       oe;
    logic       next_oe;
    code_t      hold;
    code_t      next_hold;
    code_t      sar;
    code_t      next_sar;
    code_t      mask;
    code_t      next_mask;
    logic [5:0] conv_cnt;
    logic [5:0] next_conv;
    logic [2:0] ovh_cnt;
    logic [2:0] next_ovh;
    code_t      result;
    code_t      next_result;
    logic       chan;
    logic       next_chan;
    logic       pd;
    logic       next_pd;
    logic       smp;
    logic       next_smp;
    logic       done;
    logic       next_done;
    logic       abort;
    logic       next_abort;

    // Pins held until second and third stage agree
    assign pin_raw      = {link.frame_sync_in, link.select_or_sync_n, link.sclk};
    assign next_pin_lvl = ((sync_b ~^ sync_c) & sync_c) | ((sync_b ^ sync_c) & pin_lvl);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sync_a   <= `PIN_IDLE;
            sync_b   <= `PIN_IDLE;
            sync_c   <= `PIN_IDLE;
            pin_lvl  <= `PIN_IDLE;
            pin_prev <= `PIN_IDLE;
        end
        else
        begin
            sync_a   <= pin_raw;
            sync_b   <= sync_a;
            sync_c   <= sync_b;
            pin_lvl  <= next_pin_lvl;
            pin_prev <= pin_lvl;
        end
    end

    // Edge events on the filtered pins
    assign sclk_rise = pin_lvl[`PIN_SCLK] & ~pin_prev[`PIN_SCLK];
    assign sclk_fall = ~pin_lvl[`PIN_SCLK] & pin_prev[`PIN_SCLK];
    assign sel_fall  = ~pin_lvl[`PIN_SEL] & pin_prev[`PIN_SEL];
    assign sel_rise  = pin_lvl[`PIN_SEL] & ~pin_prev[`PIN_SEL];
    assign sync_fall = ~pin_lvl[`PIN_SYNC] & pin_prev[`PIN_SYNC];

    // Start of cycle per variant
    assign frame_start = sel_fall                                         // see R6, R9
                       | ((VARIANT == VAR_SINGLE) && sync_fall           // see R7
                          && !pin_lvl[`PIN_SEL] && state != ST_SHIFT);   // see R19
    assign chan_in = chan ? analog_channel_one_i : analog_channel_zero_i;

    // Frame, sampling and conversion sequencing
    always_comb
    begin
        next_state  = state;
        next_fall   = fall_cnt;
        next_shift  = shift;
        next_sdo    = sdo;
        next_oe     = oe;
        next_hold   = hold;
        next_sar    = sar;
        next_mask   = mask;
        next_conv   = conv_cnt;
        next_ovh    = ovh_cnt;
        next_result = result;
        next_chan   = chan;
        next_pd     = pd;
        next_done   = 1'b0;
        next_abort  = 1'b0;
        unique case (state)
            ST_SHIFT:
            begin
                if (sclk_fall)
                begin
                    next_fall = fall_cnt + 5'h01;
                    if (fall_cnt >= `SAMPLE_FIRST)
                        next_hold = chan_in;                   // see R12
                    if (next_fall == `FRAME_BITS)
                    begin
                        next_oe    = 1'b0;                     // see R2
                        next_state = ST_CONV;                  // see R13
                        next_conv  = '0;
                        next_sar   = '0;
                        next_mask  = `SAR_TOP;
                    end
                end
                else if (sclk_rise && fall_cnt != '0)
                begin
                    next_shift = shift << 1;                   // see R3, R6
                    next_sdo   = next_shift[$high(next_shift)];
                end
            end
            ST_CONV:
            begin
                if (sclk_rise)
                begin
                    next_conv = conv_cnt + 6'h01;
                    // One approximation step per half-rate clock
                    if (conv_cnt[0] && mask != '0)
                    begin
                        if ((sar | mask) <= hold)
                            next_sar = sar | mask;             // see R5
                        next_mask = mask >> 1;
                    end
                    if (next_conv == CONV_EDGES)               // see R14, R17
                    begin
                        next_state = ST_OVERHEAD;
                        next_ovh   = '0;
                    end
                end
            end
            ST_OVERHEAD:
            begin
                next_ovh = ovh_cnt + 3'h1;
                if (ovh_cnt == OVH_LAST)                       // see R14
                begin
                    next_result = sar;                         // see R16
                    next_done   = 1'b1;
                    next_pd     = 1'b1;                        // see R18
                    next_state  = ST_WAIT;
                end
            end
            ST_IDLE, ST_WAIT:
            begin
            end
        endcase
        // End of frame on select rise
        if (sel_rise)
        begin
            if (VARIANT == VAR_DUAL)
            begin
                if (state == ST_WAIT)
                    next_chan = ~chan;                         // see R11
                else if (state == ST_SHIFT && fall_cnt >= `SHORT_MIN
                         && fall_cnt <= `SHORT_MAX)
                    next_chan = 1'b0;                          // see R10
            end
            if (state == ST_CONV || state == ST_OVERHEAD)
                next_abort = 1'b1;                             // see R15
            next_state = ST_IDLE;
            next_oe    = 1'b0;                                 // see R1
        end
        // New frame loads the previous result
        if (frame_start)
        begin
            if (state == ST_CONV || state == ST_OVERHEAD)
                next_abort = 1'b1;
            next_state = ST_SHIFT;
            next_fall  = '0;
            next_shift = {result, `PAD_BITS};                  // see R4, R16, R20
            next_sdo   = result[$high(result)];
            next_oe    = 1'b1;                                 // see R1
            next_pd    = 1'b0;                                 // see R18
        end
        next_smp = (next_state == ST_SHIFT) && (next_fall >= `SAMPLE_FIRST);
    end

    // Register the sequencing state
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state    <= ST_IDLE;
            fall_cnt <= '0;
            shift    <= '0;
            sdo      <= 1'b0;
            oe       <= 1'b0;
            hold     <= '0;
            sar      <= '0;
            mask     <= '0;
            conv_cnt <= '0;
            ovh_cnt  <= '0;
            result   <= '0;
            chan     <= 1'b0;
            pd       <= 1'b1;
            smp      <= 1'b0;
            done     <= 1'b0;
            abort    <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            fall_cnt <= next_fall;
            shift    <= next_shift;
            sdo      <= next_sdo;
            oe       <= next_oe;
            hold     <= next_hold;
            sar      <= next_sar;
            mask     <= next_mask;
            conv_cnt <= next_conv;
            ovh_cnt  <= next_ovh;
            result   <= next_result;
            chan     <= next_chan;
            pd       <= next_pd;
            smp      <= next_smp;
            done     <= next_done;
            abort    <= next_abort;
        end
    end

    // Outputs straight from registers
    assign link.sdo_data  = sdo;
    assign link.sdo_oe    = oe;
    assign result_bits_o  = result;
    assign channel_o      = chan;
    assign powered_down_o = pd;
    assign sampling_o     = smp;
    assign conv_done_o    = done;
    assign conv_abort_o   = abort;

endmodule

`default_nettype wire

// ==== rtl/adc_frame_host.sv ====
`include "adc_link_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module adc_frame_host
    import adc_link_pkg::*;
#(
    parameter int   SCLK_HALF = 5,
    parameter logic USE_SYNC  = 1'b0
)(
    input  wire logic    clk_sys_i,
    input  wire logic    rst_i,
    adc_link_if.host_end link,
    input  wire logic    start_i,
    input  wire logic    short_i,
    output var  logic    busy_o,
    output var  code_t   data_o,
    output var  logic    data_valid_o
);

    localparam int         LONG_I   = `FRAME_BITS + 2 * `CONV_CLOCKS + `HOST_MARGIN_SCLKS;
    localparam logic [5:0] LONG_LEN = 6'(LONG_I);
    localparam logic [5:0] BITS6    = {1'b0, `FRAME_BITS};
    localparam logic [7:0] HALF_M1  = 8'(SCLK_HALF - 1);

    logic        sdo_a;
    logic        sdo_b;
    logic        sdo_c;
    logic        sdo_lvl;
    logic        next_sdo_lvl;
    logic [7:0]  div_cnt;
    logic        tick;
    host_state_t state;
    host_state_t next_state;
    logic [5:0]  fall_cnt;
    logic [5:0]  next_fall;
    logic [5:0]  len;
    logic [5:0]  next_len;
    logic        sclk;
    logic        next_sclk;
    logic        frame;
    logic        next_frame;
    frame_t      cap;
    frame_t      next_cap;
    code_t       data;
    code_t       next_data;
    logic        valid;
    logic        next_valid;

    // Serial data filtered through three stages
    assign next_sdo_lvl = (sdo_b == sdo_c) ? sdo_c : sdo_lvl;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sdo_a   <= 1'b0;
            sdo_b   <= 1'b0;
            sdo_c   <= 1'b0;
            sdo_lvl <= 1'b0;
            div_cnt <= '0;
        end
        else
        begin
            sdo_a   <= link.sdo_line;
            sdo_b   <= sdo_a;
            sdo_c   <= sdo_b;
            sdo_lvl <= next_sdo_lvl;
            div_cnt <= (state == H_IDLE || tick) ? '0 : div_cnt + 8'h01;
        end
    end

    // Half-period enable for the serial clock
    assign tick = (div_cnt == HALF_M1);

    // Frame generation and capture
    always_comb
    begin
        next_state = state;
        next_fall  = fall_cnt;
        next_len   = len;
        next_sclk  = sclk;
        next_frame = frame;
        next_cap   = cap;
        next_data  = data;
        next_valid = 1'b0;
        unique case (state)
            H_IDLE:
            begin
                if (start_i)
                begin
                    next_len   = short_i ? `SHORT_FRAME_SCLKS : LONG_LEN;  // see R10
                    next_fall  = '0;
                    next_frame = 1'b1;
                    next_state = H_LEAD;
                end
            end
            H_LEAD:
            begin
                if (tick)
                    next_state = H_RUN;
            end
            H_RUN:
            begin
                if (tick && !sclk)
                begin
                    // Bit that stood through the last falling edge
                    if (fall_cnt != '0 && fall_cnt <= BITS6)
                    begin
                        next_cap = {cap[$high(cap) - 1:0], sdo_lvl};      // see R3
                        if (fall_cnt == BITS6)
                        begin
                            next_data  = next_cap[$high(next_cap) -: $bits(code_t)];
                            next_valid = 1'b1;
                        end
                    end
                    if (fall_cnt == len)
                    begin
                        next_frame = 1'b0;                             // see R15
                        next_state = H_GAP;
                    end
                    else
                        next_sclk = 1'b1;
                end
                else if (tick)
                begin
                    next_sclk = 1'b0;                                  // see R8
                    next_fall = fall_cnt + 6'h01;
                end
            end
            H_GAP:
            begin
                if (tick)
                    next_state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state    <= H_IDLE;
            fall_cnt <= '0;
            len      <= '0;
            sclk     <= 1'b0;
            frame    <= 1'b0;
            cap      <= '0;
            data     <= '0;
            valid    <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            fall_cnt <= next_fall;
            len      <= next_len;
            sclk     <= next_sclk;
            frame    <= next_frame;
            cap      <= next_cap;
            data     <= next_data;
            valid    <= next_valid;
        end
    end

    // Select grounded in frame-sync mode, else framing
    assign link.sclk             = sclk;
    assign link.select_or_sync_n = USE_SYNC ? 1'b0 : ~frame;
    assign link.frame_sync_in    = USE_SYNC ? ~frame : 1'b1;
    assign busy_o                = (state != H_IDLE);
    assign data_o                = data;
    assign data_valid_o          = valid;

endmodule

`default_nettype wire

// ==== testbench/adc_link_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none

module adc_link_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic select_or_sync_n,
    input wire logic frame_sync_in,
    input wire logic sdo_data,
    input wire logic sdo_oe
);
    logic       sclk_d;
    logic       fall;
    logic [5:0] fall_cnt;
    logic [5:0] next_fall_cnt;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // Serial clock falls counted since the frame opened
    assign fall = sclk_d & ~sclk;
    always_comb
    begin
        next_fall_cnt = fall_cnt;
        if (select_or_sync_n)
            next_fall_cnt = 6'h00;
        else if (fall && fall_cnt != 6'h3F)
            next_fall_cnt = fall_cnt + 6'h01;
    end

    // Counter and delayed clock registers
    always_ff @(posedge clk_sys_i)
    begin
        sclk_d   <= rst_i ? 1'b0 : sclk;
        fall_cnt <= rst_i ? 6'h00 : next_fall_cnt;
    end

    a_idle_released: assert property (select_or_sync_n [*8] |-> !sdo_oe)
        else $error("serial output driven while frame idle");
    a_start_drive: assert property ($fell(select_or_sync_n) |-> ##[2:10] sdo_oe)
        else $error("serial output not driven after frame start");
    a_drive_through: assert property (fall && fall_cnt == 6'h0F |-> sdo_oe)
        else $error("serial output released before last bit");
    a_release_after: assert property (fall && fall_cnt == 6'h0F |-> ##8 !sdo_oe)
        else $error("serial output still driven after last bit");
    a_change_rising: assert property (
        sdo_oe && $past(sdo_oe) && $changed(sdo_data) |-> sclk)
        else $error("data bit changed outside clock high phase");
    a_pad_zero: assert property (
        fall && fall_cnt >= 6'h0C && fall_cnt <= 6'h0F |-> sdo_oe && !sdo_data)
        else $error("trailing bit not driven low");
    a_clk_idle_low: assert property (select_or_sync_n |-> !sclk)
        else $error("serial clock high outside frame");
    a_frame_length: assert property ($rose(select_or_sync_n) |->
        (fall_cnt >= 6'h04 && fall_cnt <= 6'h07) || fall_cnt >= 6'h2C)
        else $error("frame closed at an illegal clock count");
endmodule

`default_nettype wire

// ==== testbench/tb_serial_adc_frame_interface.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_serial_adc_frame_interface;
    import adc_link_pkg::*;

    localparam int HALF = 8;

    logic        clk_sys_i;
    logic        rst_i;
    logic        start_i;
    logic        short_i;
    code_t       ch0;
    code_t       ch1;
    code_t       res_a;
    code_t       res_b;
    code_t       data;
    code_t       exp_res;
    code_t       expb;
    logic        chan_a;
    logic        chan_b;
    logic        pd_a;
    logic        abort_b;
    logic        busy;
    logic        valid;
    logic        exp_ch;
    logic        chb;
    logic        b_sclk;
    logic        b_sel;
    logic        sclk_q = 1'b0;
    logic [15:0] wsh = 16'h0000;
    logic [4:0]  wcnt = 5'h00;
    int          error_cnt = 0;
    int          check_count = 0;
    int          abort_cnt = 0;
    int          flen[6] = '{47, 4, 47, 7, 47, 20};

    adc_link_if link ();
    adc_link_if link_b ();

    assign link_b.sclk             = b_sclk;
    assign link_b.select_or_sync_n = b_sel;
    assign link_b.frame_sync_in    = 1'b1;

    adc_frame_host #(.SCLK_HALF(HALF), .USE_SYNC(1'b0)) i_adc_frame_host (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link), .start_i(start_i),
        .short_i(short_i), .busy_o(busy), .data_o(data), .data_valid_o(valid));

    adc_frame_device #(.VARIANT(VAR_DUAL)) i_adc_frame_device (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
        .analog_channel_zero_i(ch0), .analog_channel_one_i(ch1),
        .result_bits_o(res_a), .channel_o(chan_a), .powered_down_o(pd_a),
        .sampling_o(), .conv_done_o(), .conv_abort_o());

    adc_frame_device #(.VARIANT(VAR_DUAL)) i_adc_frame_device_b (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link_b),
        .analog_channel_zero_i(ch0), .analog_channel_one_i(ch1),
        .result_bits_o(res_b), .channel_o(chan_b), .powered_down_o(),
        .sampling_o(), .conv_done_o(), .conv_abort_o(abort_b));

    adc_link_assertions i_adc_link_assertions (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk(link.sclk),
        .select_or_sync_n(link.select_or_sync_n), .frame_sync_in(link.frame_sync_in),
        .sdo_data(link.sdo_data), .sdo_oe(link.sdo_oe));

    // Clock generator
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // Frame bits on the wire at each clock fall, plus abort pulses
    always @(posedge clk_sys_i)
    begin
        sclk_q <= link.sclk;
        if (abort_b === 1'b1)
            abort_cnt++;
        if (link.select_or_sync_n)
            wcnt <= 5'h00;
        else if (sclk_q && !link.sclk && wcnt < 5'h10)
        begin
            wsh  <= {wsh[14:0], link.sdo_line};
            wcnt <= wcnt + 5'h01;
        end
    end

    function automatic code_t pick(input logic ch, input code_t a, input code_t b);
        return ch ? b : a;
    endfunction

    function automatic logic next_chan(input int n, input logic ch);
        if (n >= 45)
            return ~ch;
        if (n >= 4 && n <= 7)
            return 1'b0;
        return ch;
    endfunction

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One host frame, long or short, then its expectations
    task automatic host_frame(input logic shrt, input code_t c0, input code_t c1);
        logic  seen;
        code_t got;
        int    n;
        seen = 1'b0;
        got  = 12'h000;
        ch0     <= c0;
        ch1     <= c1;
        start_i <= 1'b1;
        short_i <= shrt;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        @(posedge clk_sys_i);
        for (n = 0; n < 2000 && busy === 1'b1; n++)
        begin
            @(posedge clk_sys_i);
            if (valid === 1'b1)
            begin
                seen = 1'b1;
                got  = data;
            end
        end
        check_val("data valid", {15'h0000, ~shrt}, {15'h0000, seen});
        if (!shrt)
        begin
            check_val("host data", {4'h0, exp_res}, {4'h0, got});
            check_val("wire frame", {exp_res, 4'h0}, wsh);
            exp_res = pick(exp_ch, c0, c1);
            exp_ch  = ~exp_ch;
            check_val("power down", 16'h0001, {15'h0000, pd_a});
        end
        else
            exp_ch = 1'b0;
        check_val("result", {4'h0, exp_res}, {4'h0, res_a});
        check_val("channel", {15'h0000, exp_ch}, {15'h0000, chan_a});
    endtask

    // Hand-driven frame of n clocks on the second link
    task automatic drive_frame(input int n);
        b_sel <= 1'b0;
        repeat (HALF) @(posedge clk_sys_i);
        repeat (n)
        begin
            b_sclk <= 1'b1;
            repeat (HALF) @(posedge clk_sys_i);
            b_sclk <= 1'b0;
            repeat (HALF) @(posedge clk_sys_i);
        end
        b_sel <= 1'b1;
        repeat (4 * HALF) @(posedge clk_sys_i);
    endtask

    // Watchdog
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        error_cnt++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        rst_i   = 1'b1;
        start_i = 1'b0;
        short_i = 1'b0;
        ch0     = 12'h000;
        ch1     = 12'h000;
        b_sclk  = 1'b0;
        b_sel   = 1'b1;
        exp_res = 12'h000;
        exp_ch  = 1'b0;
        chb     = 1'b0;
        void'($urandom(32'h97EB97AA));
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        host_frame(1'b0, 12'h000, 12'h123);
        host_frame(1'b0, 12'h456, 12'hFFF);
        host_frame(1'b0, 12'h789, 12'hABC);
        host_frame(1'b1, 12'h321, 12'h654);
        repeat (12)
            host_frame($urandom_range(3) == 0, 12'($urandom), 12'($urandom));
        foreach (flen[i])
        begin
            expb = (flen[i] >= 45) ? pick(chb, ch0, ch1) : res_b;
            drive_frame(flen[i]);
            chb = next_chan(flen[i], chb);
            check_val("fault result", {4'h0, expb}, {4'h0, res_b});
            check_val("fault channel", {15'h0000, chb}, {15'h0000, chan_b});
        end
        check_val("abort count", 16'h0001, 16'(abort_cnt));
        give_verdict();
    end
endmodule

`default_nettype wire
